/* File: pkg/sar_adc_defines.vh */
// constants for the eight-channel sequencer of a 10-bit SAR converter
// assumes a 50 MHz clock and a 16-bit register port indexed by word

`ifndef SAR_ADC_DEFINES_VH
`define SAR_ADC_DEFINES_VH

// ---------------------------------------------------------------
// register indices (word index on the register port)
// ---------------------------------------------------------------
`define IDX_RESULT_TOP 4'h7
`define IDX_CSR        4'h8
`define IDX_CTRL       4'h9

// ---------------------------------------------------------------
// control/status fields
// ---------------------------------------------------------------
`define CSR_DONE       7
`define CSR_IRQ_EN     6
`define CSR_START      5
`define CSR_CHAN_BAD   3
`define CSR_RESET      8'h00
`define CHAN_RESET     4'h0

// ---------------------------------------------------------------
// trigger/mode control fields
// ---------------------------------------------------------------
`define CTRL_TRG_HI    7
`define CTRL_TRG_LO    6
`define CTRL_SCAN_EN   5
`define CTRL_SCAN_W    4
`define CTRL_RESET     4'h0
`define TRG_NONE       2'h0
`define TRG_PULSE      2'h1
`define TRG_TIMER8     2'h2
`define TRG_PIN        2'h3

// ---------------------------------------------------------------
// result layout
// ---------------------------------------------------------------
`define RES_PAD        6'h00
`define RES_RESET      10'h000
`define RES_FIRST_BIT  10'h200

// ---------------------------------------------------------------
// timing: one sample slot pair plus ten step slots
// ---------------------------------------------------------------
`define CLK_MHZ        50
`define CONV_TIME_NS   7400
`define CONV_CYC       ((`CONV_TIME_NS * `CLK_MHZ) / 1000)
`define STEP_SLOTS     12
`define STEP_CYC       (`CONV_CYC / `STEP_SLOTS)
`define SAMPLE_CYC     (2 * `STEP_CYC)

`endif

/* File: verilog/sar_step_engine.v */
// successive-approximation engine: sample phase then ten trials
// assumes comparator output is asynchronous and high when the
// held input is at or above the trial code

`timescale 1ns/1ps
`include "sar_adc_defines.vh"

module sar_step_engine (
  clock,
  reset_n,
  clk_en,
  start,
  abort,
  comp_in,
  sample_hold,
  dac_code,
  done,
  result
);
  input  wire       clock;       // core clock
  input  wire       reset_n;     // async reset, low
  input  wire       clk_en;      // freezes state when low
  input  wire       start;       // one-cycle launch
  input  wire       abort;       // drop conversion
  input  wire       comp_in;     // comparator, async
  output reg        sample_hold; // hold circuit tracks input
  output reg  [9:0] dac_code;    // trial code for the dac
  output reg        done;        // one-cycle end pulse
  output reg  [9:0] result;      // final code

  localparam S_IDLE   = 2'h0;
  localparam S_SAMPLE = 2'h1;
  localparam S_STEP   = 2'h2;

  localparam integer SAMPLE_LAST = `SAMPLE_CYC - 1;
  localparam integer STEP_LAST   = `STEP_CYC - 1;

  reg [1:0] state_q;   // engine state
  reg [6:0] cnt_q;     // cycles within a slot
  reg [9:0] mask_q;    // bit under trial, one-hot
  reg       comp_s1_q; // synchroniser stage one
  reg       comp_s2_q; // synchroniser stage two

  // -------------------------------------------------------------
  // comparator synchroniser
  // -------------------------------------------------------------
  // two stages; slots are long so the lag costs nothing
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      comp_s1_q <= 1'b0;
      comp_s2_q <= 1'b0;
    end else if (clk_en) begin
      comp_s1_q <= comp_in;
      comp_s2_q <= comp_s1_q;
    end
  end

  // -------------------------------------------------------------
  // sample then trial sequence
  // -------------------------------------------------------------
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_q     <= S_IDLE;
      cnt_q       <= 7'h00;
      mask_q      <= 10'h000;
      sample_hold <= 1'b0;
      dac_code    <= `RES_RESET;
      done        <= 1'b0;
      result      <= `RES_RESET;
    end else if (clk_en) begin
      done <= 1'b0;
      if (abort) begin
        // abort wins over everything, even a launch
        state_q     <= S_IDLE;
        sample_hold <= 1'b0;
      end else begin
        case (state_q)
          S_IDLE: begin
            if (start) begin
              state_q     <= S_SAMPLE;
              sample_hold <= 1'b1;
              cnt_q       <= 7'h00;
            end
          end
          S_SAMPLE: begin
            if (cnt_q == SAMPLE_LAST[6:0]) begin
              state_q     <= S_STEP;
              sample_hold <= 1'b0;
              cnt_q       <= 7'h00;
              mask_q      <= `RES_FIRST_BIT; // msb first
              dac_code    <= `RES_FIRST_BIT;
            end else begin
              cnt_q <= cnt_q + 7'h01;
            end
          end
          S_STEP: begin
            if (cnt_q == STEP_LAST[6:0]) begin
              cnt_q  <= 7'h00;
              mask_q <= mask_q >> 1;
              // keep the bit when input is not below trial
              dac_code <= (comp_s2_q ? dac_code : dac_code & ~mask_q)
                          | (mask_q >> 1);
              if (mask_q[0]) begin
                // tenth trial decided; bounded to 12 slots
                state_q <= S_IDLE;
                done    <= 1'b1;
                result  <= comp_s2_q ? dac_code : dac_code & ~mask_q;
              end
            end else begin
              cnt_q <= cnt_q + 7'h01;
            end
          end
          default: begin
            state_q <= S_IDLE;
          end
        endcase
      end
    end
  end

endmodule // sar_step_engine

/* File: verilog/sar_adc_sequencer.v */
// register port, channel sequencer and start logic of the converter
// assumes a 16-bit word-wide register port on the core clock, timer
// pulses on the same clock and an asynchronous external trigger pin

`timescale 1ns/1ps
`include "sar_adc_defines.vh"

module sar_adc_sequencer (
  clock,
  reset_n,
  clk_en,
  bus_sel,
  bus_write,
  bus_dma,
  bus_addr,
  bus_wdata,
  bus_rdata,
  pulse_timer_trig,
  eight_bit_timer_trig,
  ext_start_trigger_n,
  comp_in,
  sample_hold,
  dac_code,
  analog_sel,
  conv_done_irq
);
  input  wire        clock;                // core clock, 50 MHz
  input  wire        reset_n;              // async reset, low
  input  wire        clk_en;               // freezes state when low
  input  wire        bus_sel;              // access this cycle
  input  wire        bus_write;            // 1 write, 0 read
  input  wire        bus_dma;              // access made by dma
  input  wire [3:0]  bus_addr;             // register word index
  input  wire [15:0] bus_wdata;            // write data
  output reg  [15:0] bus_rdata;            // read data, next cycle
  input  wire        pulse_timer_trig;     // pulse timer start
  input  wire        eight_bit_timer_trig; // 8-bit timer start
  input  wire        ext_start_trigger_n;  // start pin, low active
  input  wire        comp_in;              // comparator output
  output wire        sample_hold;          // track/hold command
  output wire [9:0]  dac_code;             // trial code
  output reg  [2:0]  analog_sel;           // input mux select
  output wire        conv_done_irq;        // end interrupt, level

  // sequencer states
  localparam S_IDLE   = 2'h0;
  localparam S_LAUNCH = 2'h1;
  localparam S_WAIT   = 2'h2;

  // -------------------------------------------------------------
  // storage
  // -------------------------------------------------------------
  reg        conv_done_flag_q;  // end flag
  reg        done_armed_q;      // flag was read as one
  reg        done_irq_enable_q; // interrupt enable
  reg        conv_start_bit_q;  // start / busy bit
  reg  [3:0] chan_sel_q;        // channel select field
  reg  [1:0] trigger_sel_q;     // hardware start source
  reg        scan_enable_q;     // scan versus single
  reg        scan_width_sel_q;  // eight versus four wide
  reg  [1:0] state_q;           // sequencer state
  reg  [9:0] result_q [0:7];    // one result per channel
  reg        ext_s1_q;          // pin synchroniser one
  reg        ext_s2_q;          // pin synchroniser two
  reg        ext_prev_q;        // last synced pin level

  // -------------------------------------------------------------
  // decode
  // -------------------------------------------------------------
  wire take      = bus_sel & clk_en;            // access taken
  wire is_result = (bus_addr <= `IDX_RESULT_TOP);
  wire csr_wr    = take & bus_write & (bus_addr == `IDX_CSR);
  wire ctrl_wr   = take & bus_write & (bus_addr == `IDX_CTRL);
  wire csr_rd    = take & ~bus_write & (bus_addr == `IDX_CSR);
  wire res_rd    = take & ~bus_write & is_result;

  // engine handshake
  wire       eng_done;          // engine finished a channel
  wire [9:0] eng_result;        // its code
  wire       eng_start;         // launch pulse
  wire       halt;              // stop request

  // -------------------------------------------------------------
  // channel group limits
  // -------------------------------------------------------------
  // a start written together with its channel field must use the
  // new field, not the one still held from before the write
  wire [3:0] chan_now = csr_wr ? bus_wdata[3:0] : chan_sel_q;
  // the prohibited top code is refused rather than guessed at
  wire       chan_ok = ~chan_now[`CSR_CHAN_BAD];
  wire       scan_four = scan_enable_q & ~scan_width_sel_q;
  reg  [2:0] first_ch;          // first channel of the group
  wire [2:0] last_ch = chan_sel_q[2:0];

  // picks the group start from mode and half bit
  always @* begin
    if (scan_four)
      first_ch = {chan_now[2], 2'b00};
    else if (scan_enable_q)
      first_ch = 3'h0;
    else
      first_ch = chan_now[2:0];
  end

  // -------------------------------------------------------------
  // start sources
  // -------------------------------------------------------------
  wire pin_fall = ext_prev_q & ~ext_s2_q;  // falling edge of pin
  reg  hw_trig;                            // selected hw start

  // only one hardware source at a time is honoured
  always @* begin
    case (trigger_sel_q)
      `TRG_PULSE:  hw_trig = pulse_timer_trig;
      `TRG_TIMER8: hw_trig = eight_bit_timer_trig;
      `TRG_PIN:    hw_trig = pin_fall;
      default:     hw_trig = 1'b0;
    endcase
  end

  wire idle    = (state_q == S_IDLE);
  wire sw_go   = csr_wr & bus_wdata[`CSR_START];
  // a start while already running is not a restart
  wire go      = idle & chan_ok & (sw_go | hw_trig);
  assign halt  = csr_wr & ~bus_wdata[`CSR_START];

  // end of one channel and of the whole group
  wire ch_end    = (state_q == S_WAIT) & eng_done & ~halt;
  wire group_end = ch_end & (analog_sel == last_ch);
  wire single    = ~scan_enable_q;

  assign eng_start = (state_q == S_LAUNCH) & ~halt;

  // -------------------------------------------------------------
  // external pin synchroniser
  // -------------------------------------------------------------
  // pin idles high, so reset to high to avoid a false edge
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ext_s1_q   <= 1'b1;
      ext_s2_q   <= 1'b1;
      ext_prev_q <= 1'b1;
    end else if (clk_en) begin
      ext_s1_q   <= ext_start_trigger_n;
      ext_s2_q   <= ext_s1_q;
      ext_prev_q <= ext_s2_q;
    end
  end

  // -------------------------------------------------------------
  // sequencer
  // -------------------------------------------------------------
  // channel pointer doubles as the analog mux select
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_q    <= S_IDLE;
      analog_sel <= 3'h0;
    end else if (clk_en) begin
      if (halt) begin
        state_q <= S_IDLE;
      end else begin
        case (state_q)
          S_IDLE: begin
            if (go) begin
              state_q    <= S_LAUNCH;
              analog_sel <= first_ch;
            end
          end
          S_LAUNCH: begin
            state_q <= S_WAIT;
          end
          S_WAIT: begin
            if (eng_done) begin
              if (single) begin
                state_q <= S_IDLE;
              end else begin
                // wrap to the group start and keep going
                state_q <= S_LAUNCH;
                if (analog_sel == last_ch)
                  analog_sel <= first_ch;
                else
                  analog_sel <= analog_sel + 3'h1;
              end
            end
          end
          default: begin
            state_q <= S_IDLE;
          end
        endcase
      end
    end
  end

  // -------------------------------------------------------------
  // result registers
  // -------------------------------------------------------------
  // each code lands only in its own channel's slot
  always @(posedge clock or negedge reset_n) begin : res_store
    integer i;
    if (!reset_n) begin
      for (i = 0; i < 8; i = i + 1)
        result_q[i] <= `RES_RESET;
    end else if (clk_en) begin
      if (ch_end)
        result_q[analog_sel] <= eng_result;
    end
  end

  // -------------------------------------------------------------
  // start bit
  // -------------------------------------------------------------
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      conv_start_bit_q <= 1'b0;
    end else if (clk_en) begin
      if (halt)
        conv_start_bit_q <= 1'b0;
      else if (go)
        conv_start_bit_q <= 1'b1;
      else if (ch_end & single)
        conv_start_bit_q <= 1'b0;
    end
  end

  // -------------------------------------------------------------
  // done flag
  // -------------------------------------------------------------
  // a fresh end event beats any clear in the same cycle
  // single mode ends at its one channel even if the field moved
  wire done_set = ch_end & (single | (analog_sel == last_ch));
  wire sw_clr   = csr_wr & ~bus_wdata[`CSR_DONE] & done_armed_q;
  wire dma_clr  = res_rd & bus_dma;
  wire done_d   = done_set | (conv_done_flag_q & ~(sw_clr | dma_clr));

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      conv_done_flag_q <= 1'b0;
      done_armed_q     <= 1'b0;
    end else if (clk_en) begin
      conv_done_flag_q <= done_d;
      // arming drops with any clear; a new event must be read again
      done_armed_q <= done_d & ~(sw_clr | dma_clr) &
                      (done_armed_q | (csr_rd & conv_done_flag_q));
    end
  end

  // -------------------------------------------------------------
  // configuration bits
  // -------------------------------------------------------------
  // bit 4 of the status register has no storage at all
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      done_irq_enable_q <= 1'b0;
      chan_sel_q        <= `CHAN_RESET;
      trigger_sel_q     <= `TRG_NONE;
      scan_enable_q     <= 1'b0;
      scan_width_sel_q  <= 1'b0;
    end else if (clk_en) begin
      if (csr_wr) begin
        done_irq_enable_q <= bus_wdata[`CSR_IRQ_EN];
        chan_sel_q        <= bus_wdata[3:0];
      end
      if (ctrl_wr) begin
        trigger_sel_q    <= bus_wdata[`CTRL_TRG_HI:`CTRL_TRG_LO];
        scan_enable_q    <= bus_wdata[`CTRL_SCAN_EN];
        scan_width_sel_q <= bus_wdata[`CTRL_SCAN_W];
      end
    end
  end

  // -------------------------------------------------------------
  // read data
  // -------------------------------------------------------------
  // software may clear with write then read back, so the flag
  // must show its new value on the very next read
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      bus_rdata <= 16'h0000;
    end else if (clk_en) begin
      if (take & ~bus_write) begin
        if (is_result)
          // byte halves are not split; word reads only
          bus_rdata <= {result_q[bus_addr[2:0]], `RES_PAD};
        else if (bus_addr == `IDX_CSR)
          bus_rdata <= {8'h00, conv_done_flag_q, done_irq_enable_q,
                        conv_start_bit_q, 1'b0, chan_sel_q};
        else if (bus_addr == `IDX_CTRL)
          bus_rdata <= {8'h00, trigger_sel_q, scan_enable_q,
                        scan_width_sel_q, `CTRL_RESET};
        else
          bus_rdata <= 16'h0000;                   // unmapped
      end
    end
  end

  // -------------------------------------------------------------
  // interrupt
  // -------------------------------------------------------------
  assign conv_done_irq = conv_done_flag_q & done_irq_enable_q;

  // -------------------------------------------------------------
  // conversion engine
  // -------------------------------------------------------------
  sar_step_engine u_engine (
    .clock       (clock),
    .reset_n     (reset_n),
    .clk_en      (clk_en),
    .start       (eng_start),
    .abort       (halt),
    .comp_in     (comp_in),
    .sample_hold (sample_hold),
    .dac_code    (dac_code),
    .done        (eng_done),
    .result      (eng_result)
  );

endmodule // sar_adc_sequencer

/* File: verification/sar_adc_sequencer_asserts.sv */
// port-level checker for the converter sequencer
// assumes one clock domain; shadows of csr and mode come from writes
`timescale 1ns/1ps
module sar_adc_checker (
  input logic        clock,
  input logic        reset_n,
  input logic        clk_en,
  input logic        bus_sel,
  input logic        bus_write,
  input logic        bus_dma,
  input logic [3:0]  bus_addr,
  input logic [15:0] bus_wdata,
  input logic [15:0] bus_rdata,
  input logic        sample_hold,
  input logic [9:0]  dac_code,
  input logic [2:0]  analog_sel,
  input logic        conv_done_irq
);
  // ------------------------------------------------------------
  // write shadows
  // ------------------------------------------------------------
  wire       wr = bus_sel && clk_en && bus_write;  // write taken
  wire       rd = bus_sel && clk_en && !bus_write; // read taken
  reg  [3:0] chan_q;                                // channel bits
  reg        ie_q;                                  // irq enable
  reg        scan_q;                                // scan mode
  reg        wide_q;                                // eight-wide scan
  // follow writes only; refused starts still load the channel bits
  always @(posedge clock or negedge reset_n)
    if (!reset_n) {chan_q, ie_q, scan_q, wide_q} <= 7'h00;
    else if (wr && bus_addr == 4'h8)
      {ie_q, chan_q} <= {bus_wdata[6], bus_wdata[3:0]};
    else if (wr && bus_addr == 4'h9) {scan_q, wide_q} <= bus_wdata[5:4];
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_low_bits_zero: assert property (
    rd && bus_addr < 4'h8 |=> bus_rdata[5:0] == 6'h00)
    else $error("result low bits not zero");
  a_bit4_reads_zero: assert property (
    rd && bus_addr == 4'h8 |=> bus_rdata[4] == 1'b0)
    else $error("reserved csr bit not zero");
  a_irq_needs_enable: assert property (
    conv_done_irq |-> ie_q) else $error("irq without enable");
  a_one_keeps_done: assert property (
    wr && bus_addr == 4'h8 && bus_wdata[7:6] == 2'h3 && conv_done_irq
    |=> conv_done_irq) else $error("writing one cleared done");
  a_dma_clears_done: assert property (
    rd && bus_dma && bus_addr < 4'h8 && !sample_hold |=> !conv_done_irq)
    else $error("dma read left done set");
  a_sample_held: assert property (
    $rose(sample_hold) |-> sample_hold[*8]) else $error("short sample");
  a_msb_trial_first: assert property (
    $fell(sample_hold) |-> ##[0:2] dac_code == 10'h200)
    else $error("first trial not msb");
  a_single_channel: assert property (
    sample_hold && !scan_q |-> analog_sel == chan_q[2:0])
    else $error("single mode wrong input");
  a_quad_group: assert property (
    sample_hold && scan_q && !wide_q |-> analog_sel[2] == chan_q[2]
    && analog_sel[1:0] <= chan_q[1:0]) else $error("quad scan range");
  a_wide_group: assert property (
    sample_hold && scan_q && wide_q |-> analog_sel <= chan_q[2:0])
    else $error("wide scan range");
  a_reset_idle: assert property (
    $rose(reset_n) |-> !sample_hold && !conv_done_irq)
    else $error("not idle after reset");
  c_wide_scan: cover property (sample_hold && scan_q && wide_q);
  c_dma_read: cover property (rd && bus_dma && conv_done_irq);
  c_irq_rise: cover property ($rose(conv_done_irq));
endmodule // sar_adc_checker
bind sar_adc_sequencer sar_adc_checker sar_adc_checker_i (
  .clock(clock), .reset_n(reset_n), .clk_en(clk_en),
  .bus_sel(bus_sel), .bus_write(bus_write), .bus_dma(bus_dma),
  .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
  .sample_hold(sample_hold), .dac_code(dac_code),
  .analog_sel(analog_sel), .conv_done_irq(conv_done_irq));

/* File: verification/analog_front_model.sv */
// hold capacitor and comparator standing in for the analog side
// assumes ten bits of level per input, input 0 in the low bits
`timescale 1ns/1ps
module analog_front_model (
  input  wire logic        clock,
  input  wire logic        sample_hold,
  input  wire logic [2:0]  analog_sel,
  input  wire logic [9:0]  dac_code,
  input  wire logic [79:0] levels,
  output logic             comp_in
);
  logic [9:0] held_q = 10'h155; // level kept on the hold cap
  // track the chosen input while sampling, frozen during trials
  always @(posedge clock)
    if (sample_hold) held_q <= levels[analog_sel * 10 +: 10];
  // ideal comparator: no offset, so the code must match exactly
  assign comp_in = (held_q >= dac_code);
endmodule // analog_front_model

/* File: verification/testbench.sv */
// self-checking bench for the converter sequencer
// assumes the ideal analog model, so results equal the input levels
`timescale 1ns/1ps
module testbench;
  logic            clock = 0, reset_n = 0, clk_en = 1;
  logic            bus_sel = 0, bus_write = 0, bus_dma = 0;
  logic [3:0]      bus_addr = 4'h0;
  logic [15:0]     bus_wdata = 16'h0000, bus_rdata, rd, prev;
  logic            pulse_timer_trig = 0, eight_bit_timer_trig = 0;
  logic            ext_start_trigger_n = 1, comp_in, sample_hold;
  logic            conv_done_irq;
  logic [9:0]      dac_code;
  logic [2:0]      analog_sel;
  logic [7:0][9:0] levels;                // input level per channel
  int              n_errors = 0, num_checks = 0, t;
  sar_adc_sequencer sar_adc_sequencer_i (.clock(clock),
    .reset_n(reset_n), .clk_en(clk_en), .bus_sel(bus_sel),
    .bus_write(bus_write), .bus_dma(bus_dma), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .pulse_timer_trig(pulse_timer_trig),
    .eight_bit_timer_trig(eight_bit_timer_trig),
    .ext_start_trigger_n(ext_start_trigger_n), .comp_in(comp_in),
    .sample_hold(sample_hold), .dac_code(dac_code),
    .analog_sel(analog_sel), .conv_done_irq(conv_done_irq));
  analog_front_model analog_front_model_i (.clock(clock),
    .sample_hold(sample_hold), .analog_sel(analog_sel),
    .dac_code(dac_code), .levels(levels), .comp_in(comp_in));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  always #10 clock = ~clock;
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // one word access; an idle edge first keeps each bus_sel pulse one cycle wide
  // always a full 16-bit word, never a byte half
  task automatic acc(input logic w, d, input logic [3:0] a,
                     input logic [15:0] v);
    tick();
    bus_write = w;
    bus_dma = d;
    bus_addr = a;
    bus_wdata = v;
    bus_sel = 1;
    tick();
    bus_sel = 0;
    rd = bus_rdata;
  endtask
  task automatic chk(input logic [15:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wait_irq(input int lim);
    t = 0;
    while (conv_done_irq !== 1'b1 && t < lim) begin
      tick();
      t++;
    end
  endtask
  // pulse timers for one cycle, pin low long enough to sync
  task automatic fire(input int s);
    pulse_timer_trig = (s == 0);
    eight_bit_timer_trig = (s == 1);
    ext_start_trigger_n = (s != 2);
    tick();
    pulse_timer_trig = 0;
    eight_bit_timer_trig = 0;
    tick(3);
    ext_start_trigger_n = 1;
  endtask
  function automatic logic [15:0] exp_res(input int ch);
    return {levels[ch], 6'h00};
  endfunction
  task automatic summarize();
    if (n_errors == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // cut a hang short, well beyond the expected run
  initial begin
    #(20 * 40000);
    n_errors++;
    summarize();
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'hA20E0D51));
    foreach (levels[i]) levels[i] = 10'($urandom);
    levels[0] = 10'h000;
    levels[7] = 10'h3FF;
    tick(5);
    reset_n = 1;
    acc(0, 0, 4'h8, 0); chk(rd, 16'h0000);
    acc(0, 0, 4'h9, 0); chk(rd, 16'h0000);
    acc(1, 0, 4'h8, 16'h0010); acc(0, 0, 4'h8, 0); chk(rd, 0);
    acc(1, 0, 4'h2, 16'hFFFF); acc(0, 0, 4'h2, 0); chk(rd, 0);
    acc(1, 0, 4'h8, 16'h0028); tick(5); chk(sample_hold, 0);
    // software start on every channel, extremes included
    for (logic [3:0] c = 0; c < 8; c++) begin
      acc(1, 0, 4'h8, {12'h006, c});
      wait_irq(400); chk(t <= 370, 1);
      acc(0, 0, 4'h8, 0); chk(rd, {12'h00C, c});
      acc(1, 0, 4'h8, {12'h00C, c}); chk(conv_done_irq, 1);
      acc(1, 0, 4'h8, {12'h008, c}); chk(conv_done_irq, 0);
      acc(1, 0, 4'h8, {12'h004, c}); acc(0, 0, 4'h8, 0);
      chk(rd, {12'h004, c});
      acc(0, 0, c, 0); chk(rd, exp_res(c));
    end
    // hardware starts: only the selected source may launch
    acc(1, 0, 4'h8, 16'h0042);
    for (int g = 0; g < 4; g++) begin
      levels[2] = 10'($urandom);
      acc(1, 0, 4'h9, {8'h00, 2'(g), 6'h00});
      for (int s = 0; s < 3; s++) if (s + 1 != g) fire(s);
      tick(10); chk(sample_hold, 0);
      if (g > 0) begin
        fire(g - 1);
        wait_irq(400); chk(t <= 380, 1);
        acc(1, 0, 4'h8, 16'h0042); chk(conv_done_irq, 1);
        acc(0, 1, 4'h2, 0); chk(rd, exp_res(2));
        chk(conv_done_irq, 0);
      end
    end
    // four-wide upper half, then eight-wide from input zero
    for (int m = 0; m < 2; m++) begin
      foreach (levels[i]) levels[i] = 10'($urandom);
      acc(1, 0, 4'h9, {10'h000, 1'b1, 1'(m), 4'h0});
      acc(1, 0, 4'h8, m ? 16'h0062 : 16'h0066);
      wait_irq(1200); chk(t > 700, 1);
      for (int ch = m ? 0 : 4; ch < (m ? 3 : 7); ch++) begin
        acc(0, 0, 4'(ch), 0); chk(rd, exp_res(ch));
      end
      acc(0, 0, 4'h8, 0); chk(rd[5], 1);
      acc(1, 0, 4'h8, rd & 16'h007F); chk(conv_done_irq, 0);
      wait_irq(1200); chk(conv_done_irq, 1);
      tick(100);
      acc(1, 0, 4'h8, m ? 16'h0042 : 16'h0046);
      tick(400); chk(sample_hold, 0);
      acc(0, 0, 4'h8, 0); chk(rd[5], 0);
    end
    // frozen clock enable ignores a read
    prev = rd;
    clk_en = 0;
    acc(0, 0, 4'h3, 0); chk(rd, prev);
    clk_en = 1;
    summarize();
  end
endmodule // testbench
